// ### rtl/audio_meta_pkg.sv
package audio_meta_pkg;

    // ========================================
    // Block geometry
    localparam int         CS_BITS    = 192;
    localparam logic [7:0] LAST_FRAME = 8'hBF;
    localparam logic [2:0] BLK_WORDS  = 3'h6;
    localparam int         MEM_AW     = 5;

    // ========================================
    // Register byte offsets
    localparam logic [6:0] CTRL_OFS   = 7'h00;
    localparam logic [6:0] TXCS_OFS   = 7'h04;
    localparam logic [6:0] IFCFG_OFS  = 7'h08;
    localparam logic [6:0] RXSTAT_OFS = 7'h0C;
    localparam logic [6:0] BLKCNT_OFS = 7'h10;
    localparam int         MEM_SEL    = 6;

    // ========================================
    // Reset values
    localparam logic [15:0] CTRL_RST  = 16'h0000;
    localparam logic [19:0] TXCS_RST  = 20'h00210;
    localparam logic [24:0] IFCFG_RST = 25'h0000000;

    // ========================================
    // Control and transmit status fields
    localparam int C_TEST = 0;
    localparam int C_NPCM = 1;
    localparam int C_COPY = 2;
    localparam int C_EMPH = 3;
    localparam int C_CAT  = 8;
    localparam int T_SRC  = 0;
    localparam int T_CHA  = 4;
    localparam int T_CHB  = 8;
    localparam int T_RATE = 12;
    localparam int T_ACC  = 14;
    localparam int T_MAX  = 16;
    localparam int T_WLEN = 17;

    // ========================================
    // Information frame configuration fields
    localparam int I_CT  = 0;
    localparam int I_CC  = 4;
    localparam int I_SF  = 7;
    localparam int I_SS  = 10;
    localparam int I_SPK = 12;
    localparam int I_LSV = 20;
    localparam int I_DM  = 24;

    // ========================================
    // Channel status bit positions
    localparam int CS_FMT  = 0;
    localparam int CS_NPCM = 1;
    localparam int CS_COPY = 2;
    localparam int CS_EMPH = 3;
    localparam int CS_MODE = 6;
    localparam int CS_CAT  = 8;
    localparam int CS_SRC  = 16;
    localparam int CS_CHN  = 20;
    localparam int CS_FS   = 24;
    localparam int CS_ACC  = 28;
    localparam int CS_MAX  = 32;
    localparam int CS_WLEN = 33;

    // ========================================
    // Channel status encodings
    localparam logic       FMT_CONSUMER = 1'h0;
    localparam logic [1:0] MODE_ZERO    = 2'h0;
    localparam logic [3:0] FS_44K1      = 4'h0;
    localparam logic [3:0] FS_48K       = 4'h4;
    localparam logic [3:0] FS_32K       = 4'hC;
    localparam logic [1:0] ACC_LVL1     = 2'h2;
    localparam logic [1:0] ACC_LVL2     = 2'h0;
    localparam logic [1:0] ACC_LVL3     = 2'h1;
    localparam logic [3:0] REFER_STREAM = 4'h0;

endpackage

// ### rtl/cs_block_mem.sv
`timescale 1ns/1ps
module cs_block_mem (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             srst_i,
    // Write port
    input  wire logic                             we_i,
    input  wire logic [audio_meta_pkg::MEM_AW-1:0] waddr_i,
    input  wire logic [31:0]                      wdata_i,
    // Read port
    input  wire logic [audio_meta_pkg::MEM_AW-1:0] raddr_i,
    output logic      [31:0]                      rdata_o
);

    logic [31:0] mem [2**audio_meta_pkg::MEM_AW];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule

// ### rtl/audio_meta.sv
// Function
// - Trailer after audio data: validity, user, channel status, parity in order.
// - Status bits gathered over 192 frames into one block per subframe.
// - Only bits 0 and 1 are common; later fields depend on the format flag.
// - Bit 0 zero means consumer layout, one means professional layout.
// - Bit 1 zero for linear PCM, one for any other payload.
// - Consumer mode field at bits 6-7 is sent as 00 only.
// - Rate at bits 24-27: 0000 44.1k, 0100 48k, 1100 32k.
// - Accuracy bits 28-29: 10 level I, 00 level II, 01 level III.
// - Word length code at bits 33-35 is decoded against bit 32.
// - Status bits carried on the video link default to consumer format.
// - Zero frame field means refer to stream header; use status bits instead.
// - Coding type is sent as zero unless test mode is on.
// - Coding type and channel count share frame data byte 1.
// - Channel count is zero or a code for 2 to 8 channels.
// - Sampling frequency code is sent as zero unless test mode is on.
// - Sample size code is sent as zero unless test mode is on.
// - Sampling frequency and sample size share frame data byte 2.
// - Speaker map selects one of 32 arrangements for channels 1 to 8.
// - Speaker map is carried in frame data byte 4.
// - Level shift and downmix inhibit share frame data byte 5.
// - Downmix inhibit zero permits downmix, one prohibits it.
`timescale 1ns/1ps
module audio_meta (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // AHB-Lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // Transmit subframe trailer
    input  wire logic        tx_req_i,
    input  wire logic        tx_sub_i,
    input  wire logic [23:0] tx_sample_i,
    input  wire logic        tx_valid_i,
    input  wire logic        tx_user_i,
    output logic      [3:0]  tx_trailer_o,
    output logic             tx_trailer_vld_o,
    output logic             tx_block_start_o,
    // Receive channel status
    input  wire logic        rx_req_i,
    input  wire logic        rx_sub_i,
    input  wire logic        rx_block_start_i,
    input  wire logic        rx_cs_i,
    output logic             rx_block_done_o,
    // Received information frame bytes
    input  wire logic [7:0]  rx_if_byte1_i,
    input  wire logic [7:0]  rx_if_byte2_i,
    // Transmit information frame bytes
    output logic      [7:0]  if_byte1_o,
    output logic      [7:0]  if_byte2_o,
    output logic      [7:0]  if_byte4_o,
    output logic      [7:0]  if_byte5_o
);

    typedef struct packed {
        logic        phase;
        logic        wr;
        logic [6:0]  addr;
        logic        rdy;
        logic [31:0] rdata;
        logic [15:0] ctrl;
        logic [19:0] txcs;
        logic [24:0] ifcfg;
        logic [7:0]  if1;
        logic [7:0]  if2;
        logic [7:0]  if4;
        logic [7:0]  if5;
        logic [7:0]  tx_frame;
        logic [3:0]  trailer;
        logic        tvld;
        logic        tbs;
        logic [7:0]  rx_frame;
        logic        synced;
        logic [31:0] sh_a;
        logic [31:0] sh_b;
        logic [31:0] st0;
        logic [31:0] st1;
        logic [31:0] dec0;
        logic [31:0] dec1;
        logic        bank;
        logic        blk_valid;
        logic [15:0] blk_cnt;
        logic        done;
    } state_t;

    state_t s;
    state_t n;

    logic                             mem_we;
    logic [audio_meta_pkg::MEM_AW-1:0] mem_waddr;
    logic [31:0]                      mem_wdata;
    logic [audio_meta_pkg::MEM_AW-1:0] mem_raddr;
    logic [31:0]                      mem_rdata;
    logic [191:0]                     cs_a;
    logic [191:0]                     cs_b;
    logic [31:0]                      rx_stat;

    // ========================================
    // Channel status encoding helpers

    function automatic logic [3:0] rate_code(input logic [1:0] sel);
        if (sel == 2'h1) begin
            return audio_meta_pkg::FS_48K;
        end else if (sel == 2'h2) begin
            return audio_meta_pkg::FS_32K;
        end
        return audio_meta_pkg::FS_44K1;
    endfunction

    function automatic logic [1:0] rate_sel(input logic [3:0] code);
        if (code == audio_meta_pkg::FS_44K1) begin
            return 2'h0;
        end else if (code == audio_meta_pkg::FS_48K) begin
            return 2'h1;
        end else if (code == audio_meta_pkg::FS_32K) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    function automatic logic [1:0] acc_code(input logic [1:0] sel);
        if (sel == 2'h0) begin
            return audio_meta_pkg::ACC_LVL1;
        end else if (sel == 2'h2) begin
            return audio_meta_pkg::ACC_LVL3;
        end
        return audio_meta_pkg::ACC_LVL2;
    endfunction

    function automatic logic [1:0] acc_sel(input logic [1:0] code);
        if (code == audio_meta_pkg::ACC_LVL1) begin
            return 2'h0;
        end else if (code == audio_meta_pkg::ACC_LVL2) begin
            return 2'h1;
        end else if (code == audio_meta_pkg::ACC_LVL3) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction

    // Returns the word length in bits, or zero when not indicated.
    function automatic logic [4:0] word_bits(input logic max24,
                                             input logic [2:0] code);
        logic [4:0] b;
        b = 5'h00;
        case (code)
            3'h5: b = 5'h18;
            3'h1: b = 5'h17;
            3'h2: b = 5'h16;
            3'h3: b = 5'h15;
            3'h4: b = 5'h14;
            default: b = 5'h00;
        endcase
        if (!max24 && b != 5'h00) begin
            b = b - 5'h04;
        end
        return b;
    endfunction

    function automatic logic [191:0] build_cs(input logic [15:0] c,
                                              input logic [19:0] t,
                                              input logic [3:0]  chn);
        logic [191:0] b;
        b = '0;
        b[audio_meta_pkg::CS_FMT] = audio_meta_pkg::FMT_CONSUMER;
        b[audio_meta_pkg::CS_NPCM] = c[audio_meta_pkg::C_NPCM];
        b[audio_meta_pkg::CS_COPY] = c[audio_meta_pkg::C_COPY];
        b[audio_meta_pkg::CS_EMPH +: 3] = c[audio_meta_pkg::C_EMPH +: 3];
        b[audio_meta_pkg::CS_MODE +: 2] = audio_meta_pkg::MODE_ZERO;
        b[audio_meta_pkg::CS_CAT +: 8] = c[audio_meta_pkg::C_CAT +: 8];
        b[audio_meta_pkg::CS_SRC +: 4] = t[audio_meta_pkg::T_SRC +: 4];
        b[audio_meta_pkg::CS_CHN +: 4] = chn;
        b[audio_meta_pkg::CS_FS +: 4] =
            rate_code(t[audio_meta_pkg::T_RATE +: 2]);
        b[audio_meta_pkg::CS_ACC +: 2] =
            acc_code(t[audio_meta_pkg::T_ACC +: 2]);
        b[audio_meta_pkg::CS_MAX] = t[audio_meta_pkg::T_MAX];
        b[audio_meta_pkg::CS_WLEN +: 3] = t[audio_meta_pkg::T_WLEN +: 3];
        return b;
    endfunction

    assign cs_a = build_cs(s.ctrl, s.txcs, s.txcs[audio_meta_pkg::T_CHA +: 4]);
    assign cs_b = build_cs(s.ctrl, s.txcs, s.txcs[audio_meta_pkg::T_CHB +: 4]);

    // ========================================
    // Receive status word

    // Consumer fields read as zero when the block is professional.
    always_comb begin
        rx_stat = 32'h00000000;
        rx_stat[0] = s.blk_valid;
        rx_stat[1] = s.dec0[audio_meta_pkg::CS_FMT];
        rx_stat[2] = s.dec0[audio_meta_pkg::CS_NPCM];
        if (!s.dec0[audio_meta_pkg::CS_FMT]) begin
            rx_stat[3] = s.dec0[audio_meta_pkg::CS_MODE +: 2] ==
                         audio_meta_pkg::MODE_ZERO;
            rx_stat[5:4] = rate_sel(s.dec0[audio_meta_pkg::CS_FS +: 4]);
            rx_stat[7:6] = acc_sel(s.dec0[audio_meta_pkg::CS_ACC +: 2]);
            rx_stat[8] = s.dec1[audio_meta_pkg::CS_MAX - 32];
            rx_stat[13:9] = word_bits(s.dec1[audio_meta_pkg::CS_MAX - 32],
                s.dec1[audio_meta_pkg::CS_WLEN - 32 +: 3]);
            rx_stat[25:22] = s.dec0[audio_meta_pkg::CS_CHN +: 4];
        end
        rx_stat[14] = rx_if_byte2_i[4:2] == 3'(audio_meta_pkg::REFER_STREAM);
        rx_stat[17:15] = rx_if_byte2_i[4:2];
        rx_stat[18] = rx_if_byte1_i[2:0] == 3'(audio_meta_pkg::REFER_STREAM);
        rx_stat[21:19] = rx_if_byte1_i[2:0];
    end

    // ========================================
    // Next state

    always_comb begin
        logic       c;
        logic       v;
        logic [7:0] f;
        logic       sy;
        logic [31:0] w;
        logic [31:0] rd;
        logic [3:0] ct;
        logic [2:0] sf;
        logic [1:0] ss;
        c = 1'h0;
        v = 1'h0;
        f = s.rx_frame;
        sy = s.synced;
        w = 32'h00000000;
        rd = 32'h00000000;
        ct = 4'h0;
        sf = 3'h0;
        ss = 2'h0;
        n = s;
        n.tvld = 1'h0;
        n.done = 1'h0;
        mem_we = 1'h0;
        mem_waddr = '0;
        mem_wdata = 32'h00000000;
        mem_raddr = {s.bank, haddr_i[5], haddr_i[4:2]};

        // Bus data phase: every transfer takes one wait state.
        if (s.phase) begin
            if (s.addr[audio_meta_pkg::MEM_SEL]) begin
                if (s.blk_valid && s.addr[4:2] < audio_meta_pkg::BLK_WORDS) begin
                    rd = mem_rdata;
                end
            end else if (s.addr == audio_meta_pkg::CTRL_OFS) begin
                rd = {16'h0000, s.ctrl};
            end else if (s.addr == audio_meta_pkg::TXCS_OFS) begin
                rd = {12'h000, s.txcs};
            end else if (s.addr == audio_meta_pkg::IFCFG_OFS) begin
                rd = {7'h00, s.ifcfg};
            end else if (s.addr == audio_meta_pkg::RXSTAT_OFS) begin
                rd = rx_stat;
            end else if (s.addr == audio_meta_pkg::BLKCNT_OFS) begin
                rd = {16'h0000, s.blk_cnt};
            end
            if (s.wr) begin
                if (s.addr == audio_meta_pkg::CTRL_OFS) begin
                    n.ctrl = hwdata_i[15:0];
                end else if (s.addr == audio_meta_pkg::TXCS_OFS) begin
                    n.txcs = hwdata_i[19:0];
                end else if (s.addr == audio_meta_pkg::IFCFG_OFS) begin
                    n.ifcfg = hwdata_i[24:0];
                end
            end
            n.rdata = s.wr ? 32'h00000000 : rd;
            n.phase = 1'h0;
            n.rdy = 1'h1;
        end
        if (hsel_i && htrans_i[1] && hready_i) begin
            n.phase = 1'h1;
            n.wr = hwrite_i;
            n.addr = haddr_i[6:0];
            n.rdy = 1'h0;
        end

        // Transmit trailer for each subframe.
        if (tx_req_i) begin
            c = tx_sub_i ? cs_b[s.tx_frame] : cs_a[s.tx_frame];
            v = tx_valid_i | s.ctrl[audio_meta_pkg::C_NPCM];
            n.trailer = {v, tx_user_i, c, ^{tx_sample_i, v, tx_user_i, c}};
            n.tvld = 1'h1;
            n.tbs = (s.tx_frame == 8'h00) && !tx_sub_i;
            if (tx_sub_i) begin
                n.tx_frame = (s.tx_frame == audio_meta_pkg::LAST_FRAME) ?
                             8'h00 : s.tx_frame + 8'h01;
            end
        end

        // Receive: collect words into the idle bank, swap at the boundary.
        if (rx_req_i) begin
            if (!rx_sub_i) begin
                if (rx_block_start_i) begin
                    f = 8'h00;
                    sy = 1'h1;
                end else if (f == 8'h00) begin
                    sy = 1'h0;
                end
            end
            w = rx_sub_i ? {rx_cs_i, s.sh_b[31:1]} : {rx_cs_i, s.sh_a[31:1]};
            if (rx_sub_i) begin
                n.sh_b = w;
            end else begin
                n.sh_a = w;
            end
            if (f[4:0] == 5'h1F) begin
                mem_we = sy;
                mem_waddr = {~s.bank, rx_sub_i, f[7:5]};
                mem_wdata = w;
                if (!rx_sub_i && f[7:5] == 3'h0) begin
                    n.st0 = w;
                end
                if (!rx_sub_i && f[7:5] == 3'h1) begin
                    n.st1 = w;
                end
            end
            if (rx_sub_i) begin
                if (f == audio_meta_pkg::LAST_FRAME) begin
                    f = 8'h00;
                    if (sy) begin
                        n.bank = ~s.bank;
                        n.dec0 = s.st0;
                        n.dec1 = s.st1;
                        n.blk_valid = 1'h1;
                        n.blk_cnt = s.blk_cnt + 16'h0001;
                        n.done = 1'h1;
                    end
                end else begin
                    f = f + 8'h01;
                end
            end
            n.rx_frame = f;
            n.synced = sy;
        end

        // Information frame bytes.
        if (s.ctrl[audio_meta_pkg::C_TEST]) begin
            ct = s.ifcfg[audio_meta_pkg::I_CT +: 4];
            sf = s.ifcfg[audio_meta_pkg::I_SF +: 3];
            ss = s.ifcfg[audio_meta_pkg::I_SS +: 2];
        end else begin
            ct = audio_meta_pkg::REFER_STREAM;
            sf = 3'(audio_meta_pkg::REFER_STREAM);
            ss = 2'(audio_meta_pkg::REFER_STREAM);
        end
        n.if1 = {ct, 1'h0, s.ifcfg[audio_meta_pkg::I_CC +: 3]};
        n.if2 = {3'h0, sf, ss};
        n.if4 = s.ifcfg[audio_meta_pkg::I_SPK +: 8];
        n.if5 = {s.ifcfg[audio_meta_pkg::I_DM],
                 s.ifcfg[audio_meta_pkg::I_LSV +: 4], 3'h0};
    end

    // ========================================
    // State register

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0;
            s.rdy <= 1'h1;
            s.ctrl <= audio_meta_pkg::CTRL_RST;
            s.txcs <= audio_meta_pkg::TXCS_RST;
            s.ifcfg <= audio_meta_pkg::IFCFG_RST;
        end else begin
            s <= n;
        end
    end

    cs_block_mem u_mem (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .we_i    (mem_we),
        .waddr_i (mem_waddr),
        .wdata_i (mem_wdata),
        .raddr_i (mem_raddr),
        .rdata_o (mem_rdata)
    );

    assign hrdata_o         = s.rdata;
    assign hreadyout_o      = s.rdy;
    assign hresp_o          = 1'h0;
    assign tx_trailer_o     = s.trailer;
    assign tx_trailer_vld_o = s.tvld;
    assign tx_block_start_o = s.tbs;
    assign rx_block_done_o  = s.done;
    assign if_byte1_o       = s.if1;
    assign if_byte2_o       = s.if2;
    assign if_byte4_o       = s.if4;
    assign if_byte5_o       = s.if5;

endmodule

// ### test/audio_meta_properties.sv
`timescale 1ns/1ps
module audio_meta_checker (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        hsel_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic        hresp_o,
    // Transmit side
    input wire logic        tx_req_i,
    input wire logic        tx_sub_i,
    input wire logic [23:0] tx_sample_i,
    input wire logic        tx_valid_i,
    input wire logic        tx_user_i,
    input wire logic [3:0]  tx_trailer_o,
    input wire logic        tx_trailer_vld_o,
    input wire logic        tx_block_start_o,
    // Receive side and frame bytes
    input wire logic        rx_req_i,
    input wire logic        rx_sub_i,
    input wire logic        rx_block_done_o,
    input wire logic [7:0]  if_byte1_o,
    input wire logic [7:0]  if_byte2_o,
    input wire logic [7:0]  if_byte5_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence s_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    sequence s_done;
        $past(rx_req_i && rx_sub_i) ##1 !rx_block_done_o;
    endsequence
    property p_wait;
        hsel_i && htrans_i[1] && hready_i |=> s_wait;
    endproperty
    property p_okay;
        hresp_o == 1'b0;
    endproperty
    property p_vld;
        tx_trailer_vld_o == $past(tx_req_i);
    endproperty
    property p_par;
        tx_trailer_vld_o |->
            tx_trailer_o[0] == ^{$past(tx_sample_i), tx_trailer_o[3:1]};
    endproperty
    property p_user;
        tx_trailer_vld_o |-> tx_trailer_o[2] == $past(tx_user_i)
            && tx_trailer_o[3] >= $past(tx_valid_i);
    endproperty
    property p_start;
        tx_trailer_vld_o && tx_block_start_o |-> !$past(tx_sub_i);
    endproperty
    property p_bytes;
        if_byte1_o[3] == 1'b0 && if_byte2_o[7:5] == 3'h0
            && if_byte5_o[2:0] == 3'h0;
    endproperty
    property p_done;
        rx_block_done_o |-> s_done;
    endproperty
    a_wait: assert property (p_wait) else $error("bus wait state wrong");
    a_okay: assert property (p_okay) else $error("bus response not okay");
    a_vld: assert property (p_vld) else $error("trailer strobe late");
    a_par: assert property (p_par) else $error("trailer parity odd");
    a_user: assert property (p_user) else $error("trailer bits wrong");
    a_start: assert property (p_start) else $error("block start on B");
    a_bytes: assert property (p_bytes) else $error("frame byte pad");
    a_done: assert property (p_done) else $error("block done wrong");
endmodule
bind audio_meta audio_meta_checker chk (.*);

// ### test/cs_stream_source.sv
`timescale 1ns/1ps
module cs_stream_source (
    // Clock and start
    input  wire logic         clk_i,
    input  wire logic         go_i,
    input  wire logic [191:0] blk_i,
    // Subframe stream
    output logic              req_o,
    output logic              sub_o,
    output logic              start_o,
    output logic              cs_o
);
    initial begin
        req_o = 1'b0;
        sub_o = 1'b0;
        start_o = 1'b0;
        cs_o = 1'b0;
    end
    // Sends one block as A then B per frame, bit f in frame f.
    always @(posedge clk_i) begin
        if (go_i) begin
            for (int f = 0; f < 192; f++) begin
                for (int s = 0; s < 2; s++) begin
                    req_o   <= 1'b1;
                    sub_o   <= s[0];
                    start_o <= (f == 0) && (s == 0);
                    cs_o    <= blk_i[f];
                    @(posedge clk_i);
                end
            end
            req_o   <= 1'b0;
            start_o <= 1'b0;
            cs_o    <= ~cs_o;
        end
    end
endmodule

// ### test/audio_meta_bench.sv
`timescale 1ns/1ps
module audio_meta_bench;
    logic         clk_i = 1'b0;
    logic         srst_i = 1'b1;
    logic         hsel_i = 1'b0;
    logic [31:0]  haddr_i = 32'h0;
    logic [1:0]   htrans_i = 2'h0;
    logic         hwrite_i = 1'b0;
    logic [31:0]  hwdata_i = 32'h0;
    logic         tx_req_i = 1'b0;
    logic         tx_sub_i = 1'b0;
    logic [23:0]  tx_sample_i = 24'h0;
    logic         tx_valid_i = 1'b0;
    logic         tx_user_i = 1'b0;
    logic         go = 1'b0;
    logic [31:0]  hrdata_o, rd;
    logic         hreadyout_o, tx_vld, tx_start, rx_req, rx_sub, rx_st;
    logic         rx_cs, rx_done;
    logic [3:0]   tx_trailer_o;
    logic [7:0]   b1, b2, b4, b5;
    logic [7:0]   rx_if1 = 8'h00;
    logic [7:0]   rx_if2 = 8'h00;
    logic [191:0] blk = 192'h0;
    logic [191:0] cs_a = 192'h0;
    int           err_count = 0;
    int           n_checks = 0;
    int           cyc = 0;
    audio_meta uut (
        .clk_i(clk_i), .srst_i(srst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(), .tx_req_i(tx_req_i),
        .tx_sub_i(tx_sub_i), .tx_sample_i(tx_sample_i),
        .tx_valid_i(tx_valid_i), .tx_user_i(tx_user_i),
        .tx_trailer_o(tx_trailer_o), .tx_trailer_vld_o(tx_vld),
        .tx_block_start_o(tx_start), .rx_req_i(rx_req), .rx_sub_i(rx_sub),
        .rx_block_start_i(rx_st), .rx_cs_i(rx_cs), .rx_block_done_o(rx_done),
        .rx_if_byte1_i(rx_if1), .rx_if_byte2_i(rx_if2), .if_byte1_o(b1),
        .if_byte2_o(b2), .if_byte4_o(b4), .if_byte5_o(b5));
    cs_stream_source src (.clk_i(clk_i), .go_i(go), .blk_i(blk),
        .req_o(rx_req), .sub_o(rx_sub), .start_o(rx_st), .cs_o(rx_cs));
    always #25 clk_i = ~clk_i;
    // ========================================
    // Tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel_i   <= 1'b1;
        haddr_i  <= a;
        htrans_i <= 2'h2;
        hwrite_i <= w;
        @(posedge clk_i);
        while (!hreadyout_o) @(posedge clk_i);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        @(posedge clk_i);
        while (!hreadyout_o) @(posedge clk_i);
        rd = hrdata_o;
    endtask
    task automatic rdchk(input string nm, input logic [31:0] a,
                         input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic send(input int f, input logic s);
        tx_req_i    <= 1'b1;
        tx_sub_i    <= s;
        tx_sample_i <= 24'h5A0000 + 24'(f * 2) + 24'(s);
        tx_valid_i  <= s;
        tx_user_i   <= f[0];
        @(posedge clk_i);
        tx_req_i <= 1'b0;
        @(posedge clk_i);
        if (!s) cs_a[f] = tx_trailer_o[1];
        chk("validity", 32'h1, {31'h0, tx_trailer_o[3]});
        chk("blkstart", {31'h0, f == 0 && !s}, {31'h0, tx_start});
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    // ========================================
    // Tests
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 1'b0;
        @(posedge clk_i);
        rdchk("ctrl", 32'h00, 32'h0);
        rdchk("txcs", 32'h04, 32'h00210);
        rdchk("ifcfg", 32'h08, 32'h0);
        rdchk("blkcnt", 32'h10, 32'h0);
        rdchk("unmapped", 32'h20, 32'h0);
        chk("ifbytes", 32'h0, {b1, b2, b4, b5});
        $display("test reset done");
        bus(1'b1, 32'h08, 32'h01A1F9F5);
        @(posedge clk_i);
        chk("ifbytes", 32'h07001FD0, {b1, b2, b4, b5});
        bus(1'b1, 32'h00, 32'h1);
        @(posedge clk_i);
        chk("ifbytes", 32'h570E1FD0, {b1, b2, b4, b5});
        rdchk("ifcfg", 32'h08, 32'h01A1F9F5);
        $display("test frame bytes done");
        bus(1'b1, 32'h04, 32'h000BA213);
        bus(1'b1, 32'h00, 32'h2);
        for (int f = 0; f < 192; f++) begin
            send(f, 1'b0);
            send(f, 1'b1);
        end
        chk("txfields", 32'h2DC12, {cs_a[35:32], cs_a[29:24], cs_a[23:20],
            cs_a[7:6], cs_a[1:0]});
        $display("test transmit done");
        blk[27:24] = 4'hC;
        blk[29:28] = 2'h2;
        blk[35:33] = 3'h2;
        blk[23:20] = 4'h5;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        while (!rx_done) @(posedge clk_i);
        @(posedge clk_i);
        bus(1'b1, 32'h10, 32'hFFFF);
        bus(1'b0, 32'h0C, 32'h0);
        chk("rxstat", 32'h01446429, rd & 32'h03C47FFF);
        rdchk("memword0", 32'h40, blk[31:0]);
        rdchk("memword1", 32'h44, blk[63:32]);
        rdchk("blkcnt", 32'h10, 32'h1);
        $display("test receive done");
        blk[0] = 1'b1;
        rx_if1 <= 8'h05;
        rx_if2 <= 8'h0C;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        while (!rx_done) @(posedge clk_i);
        @(posedge clk_i);
        rdchk("rxstat", 32'h0C, 32'h00298003);
        rdchk("memword0", 32'h40, blk[31:0]);
        rdchk("blkcnt", 32'h10, 32'h2);
        $display("test professional done");
        wrap_up();
    end
endmodule
